// *** design/wpc_map.svh ***
// constants for the wiper position serial slave
`ifndef WPC_MAP_SVH
`define WPC_MAP_SVH
`define WPC_POS_W 10
`define WPC_TAPS 1024
`define WPC_NREG 4
`define WPC_ID_TYPE 4'h5
`define WPC_OP_RD_WIPER 4'h9
`define WPC_OP_WR_WIPER 4'ha
`define WPC_OP_RD_STORED 4'hb
`define WPC_OP_WR_STORED 4'hc
`define WPC_OP_XFR_TO_WIPER 4'hd
`define WPC_OP_XFR_TO_STORED 4'he
`define WPC_OP_RD_STATUS 4'h5
`define WPC_NVW_MS 10
`define WPC_CLK_KHZ 20000
`define WPC_NVW_CYCLES (`WPC_NVW_MS * `WPC_CLK_KHZ)
`endif

// *** design/wpc_pkg.sv ***
// types for the wiper position serial slave
`default_nettype none
package wpc_pkg;
	typedef logic [9:0] wpc_pos_t;
	typedef enum {WPC_IDLE, WPC_ID, WPC_INSTR, WPC_DATA, WPC_READ, WPC_DONE, WPC_SKIP} wpc_state_e;
	typedef struct packed {
		logic sck;
		logic cs_n;
		logic hold_n;
		logic mosi;
	} wpc_pins_s;
endpackage : wpc_pkg
`default_nettype wire

// *** design/wpc_sync.sv ***
// two-flop synchroniser for a group of pins
`default_nettype none
module wpc_sync #(
	parameter int W = 4,
	parameter logic [W-1:0] INIT = '1
) (
	input wire logic clk_sys, // system clock
	input wire logic sys_rst, // synchronous reset
	input wire logic [W-1:0] d, // asynchronous inputs
	output logic [W-1:0] q // synchronised outputs
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} wpc_sync_s;
	wpc_sync_s st_q, st_d;
	always_comb begin
		st_d.s1 = d;
		st_d.s2 = st_q.s1;
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_q <= {INIT, INIT};
		end else begin
			st_q <= st_d;
		end
	end
	assign q = st_q.s2;
endmodule : wpc_sync
`default_nettype wire

// *** design/wpc_tap_decode.sv ***
// one-hot decode of the wiper position onto the tap switches
`default_nettype none
module wpc_tap_decode #(
	parameter int PW = 10,
	parameter int TAPS = 1024
) (
	input wire logic clk_sys, // system clock
	input wire logic sys_rst, // synchronous reset
	input wire logic [PW-1:0] pos, // wiper position
	output logic [TAPS-1:0] tap_on // one closed switch
);
	typedef struct packed {
		logic [TAPS-1:0] taps;
	} wpc_dec_s;
	wpc_dec_s st_q, st_d;
	always_comb begin
		st_d.taps = '0;
		st_d.taps[pos] = 1'b1;
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_q.taps <= {{(TAPS-1){1'b0}}, 1'b1};
		end else begin
			st_q <= st_d;
		end
	end
	assign tap_on = st_q.taps;
	chk_tap_onehot: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$onehot(tap_on)) else $error("tap select not one-hot");
	chk_tap_follows: assert property (@(posedge clk_sys) disable iff (sys_rst)
		##1 tap_on[$past(pos)]) else $error("tap does not follow position");
endmodule : wpc_tap_decode
`default_nettype wire

// *** design/wpc_top.sv ***
// serial slave holding wiper position and four stored positions
`include "wpc_map.svh"
`default_nettype none
module wpc_top #(
	parameter int NVW_CYCLES = `WPC_NVW_CYCLES
) (
	input wire logic clk_sys, // system clock 20 MHz
	input wire logic sys_rst, // synchronous reset, power-up
	input wire logic sck, // serial clock pin
	input wire logic cs_n, // chip select pin
	input wire logic hold_n, // pause pin
	input wire logic wp_n, // write protect pin
	input wire logic mosi, // serial data in
	input wire logic slave_addr_bit0, // address pin
	input wire logic slave_addr_bit1, // address pin
	output logic miso_o, // serial data out
	output logic miso_oe_n, // low while driving
	output logic nv_write_busy, // nv write running
	output logic standby, // deselected and idle
	output logic [`WPC_TAPS-1:0] tap_on // tap switches
);
	import wpc_pkg::*;
	typedef struct packed {
		wpc_state_e st;
		logic armed;
		logic paused;
		logic sck_prev;
		logic cs_prev;
		logic [2:0] bitn;
		logic [7:0] shin;
		logic [3:0] op;
		logic [1:0] sel;
		logic rd;
		logic [7:0] shout;
		logic [1:0] byten;
		logic [9:0] data;
		logic drive;
		logic pend;
		logic [1:0] pend_sel;
		wpc_pos_t pend_val;
		logic busy;
		logic [31:0] cnt;
		logic boot;
		wpc_pos_t wiper;
		wpc_pos_t [`WPC_NREG-1:0] stored;
	} wpc_top_s;
	wpc_top_s s_q, s_d;
	wpc_pins_s pin;
	// sck idles low so the edge detector sees no false edge after reset
	wpc_sync #(.W(4), .INIT(4'b0110)) u_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.d({sck, cs_n, hold_n, mosi}),
		.q(pin)
	);
	logic wp_s1, wp_s2;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wp_s1 <= 1'b1;
			wp_s2 <= 1'b1;
		end else begin
			wp_s1 <= wp_n;
			wp_s2 <= wp_s1;
		end
	end
	logic rise, fall, cs_rise, cs_fall;
	assign rise = pin.sck & ~s_q.sck_prev;
	assign fall = ~pin.sck & s_q.sck_prev;
	assign cs_rise = pin.cs_n & ~s_q.cs_prev;
	assign cs_fall = ~pin.cs_n & s_q.cs_prev;
	logic [7:0] byte_in;
	assign byte_in = {s_q.shin[6:0], pin.mosi};
	always_comb begin
		s_d = s_q;
		s_d.sck_prev = pin.sck;
		s_d.cs_prev = pin.cs_n;
		if (s_q.boot) begin
			s_d.wiper = s_q.stored[0];
			s_d.boot = 1'b0;
		end
		if (s_q.busy) begin
			if (s_q.cnt == 32'(NVW_CYCLES - 1)) begin
				s_d.busy = 1'b0;
				s_d.stored[s_q.pend_sel] = s_q.pend_val;
			end else begin
				s_d.cnt = s_q.cnt + 32'd1;
			end
		end
		// first select fall arms the port
		if (cs_fall) begin
			s_d.armed = 1'b1;
		end
		// pause only taken while clock low
		if (!pin.sck && !pin.cs_n) begin
			s_d.paused = ~pin.hold_n;
		end
		if (pin.cs_n) begin
			s_d.drive = 1'b0;
			s_d.paused = 1'b0;
			s_d.st = WPC_IDLE;
			// nv save begins at select rise
			if (cs_rise && s_q.pend && s_q.st == WPC_DONE && wp_s2 && !s_q.busy) begin
				s_d.busy = 1'b1;
				s_d.cnt = '0;
			end
			s_d.pend = 1'b0;
		end else if (cs_fall && s_q.armed | cs_fall) begin
			s_d.st = WPC_ID;
			s_d.bitn = '0;
			s_d.byten = '0;
			s_d.pend = 1'b0;
		end else if (!s_q.paused) begin
			if (rise && s_q.st != WPC_IDLE && s_q.st != WPC_SKIP && s_q.st != WPC_DONE) begin
				s_d.shin = byte_in;
				s_d.bitn = s_q.bitn + 3'd1;
				if (s_q.bitn == 3'd7) begin
					unique case (s_q.st)
						WPC_ID: begin
							if (byte_in[7:4] == `WPC_ID_TYPE &&
								byte_in[2:1] == {slave_addr_bit1, slave_addr_bit0}) begin
								s_d.st = WPC_INSTR;
								s_d.rd = byte_in[0];
							end else begin
								s_d.st = WPC_SKIP;
							end
						end
						WPC_INSTR: begin
							// opcode and register select
							// opcode is {instruction bits, read flag}
							s_d.op = {byte_in[7:5], s_q.rd};
							s_d.sel = byte_in[3:2];
							s_d.byten = '0;
							unique case ({byte_in[7:5], s_q.rd})
								`WPC_OP_XFR_TO_WIPER: begin
									if (!s_q.busy) begin
										s_d.wiper = s_q.stored[byte_in[3:2]];
									end
									s_d.st = WPC_DONE;
								end
								`WPC_OP_XFR_TO_STORED: begin
									s_d.pend = 1'b1;
									s_d.pend_sel = byte_in[3:2];
									s_d.pend_val = s_q.wiper;
									s_d.st = WPC_DONE;
								end
								`WPC_OP_RD_WIPER: begin
									s_d.shout = {6'h0, s_q.wiper[9:8]};
									s_d.st = WPC_READ;
								end
								`WPC_OP_RD_STORED: begin
									s_d.shout = {6'h0, s_q.stored[byte_in[3:2]][9:8]};
									s_d.st = WPC_READ;
								end
								`WPC_OP_RD_STATUS: begin
									s_d.shout = {7'h0, s_q.busy};
									s_d.st = WPC_READ;
								end
								`WPC_OP_WR_WIPER, `WPC_OP_WR_STORED: begin
									s_d.st = WPC_DATA;
								end
								default: begin
									s_d.st = WPC_SKIP;
								end
							endcase
						end
						WPC_DATA: begin
							s_d.byten = s_q.byten + 2'd1;
							if (s_q.byten == 2'd0) begin
								s_d.data = {byte_in[1:0], 8'h0};
							end else begin
								s_d.st = WPC_DONE;
								if (s_q.op == `WPC_OP_WR_WIPER) begin
									s_d.wiper = {s_q.data[9:8], byte_in};
								end else begin
									// stored write waits for select rise
									s_d.pend = 1'b1;
									s_d.pend_sel = s_q.sel;
									s_d.pend_val = {s_q.data[9:8], byte_in};
								end
							end
						end
						WPC_READ: begin
							s_d.byten = s_q.byten + 2'd1;
						end
						default: begin
							s_d.st = WPC_SKIP;
						end
					endcase
				end
			end
			if (fall && s_q.st == WPC_READ) begin
				s_d.drive = (s_q.byten != 2'd2);
				if (s_q.bitn == 3'd0 && s_q.drive) begin
					s_d.shout = (s_q.op == `WPC_OP_RD_WIPER) ? s_q.wiper[7:0] :
						(s_q.op == `WPC_OP_RD_STORED) ? s_q.stored[s_q.sel][7:0] : 8'h0;
				end else if (s_q.drive) begin
					s_d.shout = {s_q.shout[6:0], 1'b0};
				end
			end
		end
		// the arming fall itself starts the first frame
		if (!s_d.armed) begin
			s_d.st = WPC_IDLE;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.st <= WPC_IDLE;
			s_q.sck_prev <= 1'b0;
			s_q.cs_prev <= 1'b1;
			s_q.boot <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end
	wpc_tap_decode #(.PW(`WPC_POS_W), .TAPS(`WPC_TAPS)) u_dec (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.pos(s_q.wiper),
		.tap_on(tap_on)
	);
	assign miso_o = s_q.shout[7];
	assign miso_oe_n = ~(s_q.drive & ~pin.cs_n);
	assign nv_write_busy = s_q.busy;
	assign standby = pin.cs_n & ~s_q.busy;
	chk_out_release: assert property (@(posedge clk_sys) disable iff (sys_rst)
		pin.cs_n |-> miso_oe_n) else $error("output driven while deselected");
	chk_nv_protect: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(cs_rise && !wp_s2 && !s_q.busy) |=> !nv_write_busy) else $error("write not blocked");
	chk_nv_finish: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$fell(nv_write_busy) |-> $past(s_q.cnt) == 32'(NVW_CYCLES - 1))
		else $error("nv write length wrong");
	chk_nv_start: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$rose(nv_write_busy) |-> $past(cs_rise)) else $error("save began without select rise");
	chk_pause_keep: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(s_q.paused && !pin.cs_n && !cs_fall) |=> $stable(s_q.bitn))
		else $error("state moved while paused");
	chk_unarmed_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!s_q.armed |-> s_q.st == WPC_IDLE) else $error("active before first select");
	chk_busy_wiper: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(s_q.busy && s_q.st != WPC_DATA && !s_q.boot) |=> $stable(s_q.wiper))
		else $error("wiper moved during nv write");
	chk_power_recall: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_q.boot |=> s_q.wiper == $past(s_q.stored[0])) else $error("no power-up recall");
endmodule : wpc_top
`default_nettype wire

// *** tb/wpc_host.sv ***
// host controller model driving the serial slave pins
`default_nettype none
module wpc_host (
	input wire logic clk_sys, // system clock
	input wire logic miso, // resolved data line
	output logic sck, // serial clock
	output logic cs_n, // select
	output logic hold_n, // pause
	output logic mosi // serial data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		hold_n = 1'b1;
		mosi = 1'b0;
	end
	// half a 400 ns link period
	task automatic half();
		repeat (4) @(negedge clk_sys);
	endtask : half
	// select low over a frame, pause high except around bit hp, where a stray clock comes while paused
	task automatic frame(input logic [31:0] tx, input int n, input int hp,
			output logic [31:0] rx);
		rx = '0;
		cs_n = 1'b0;
		half();
		for (int i = 0; i < n; i++) begin
			mosi = tx[31-i];
			if (i == hp) begin
				hold_n = 1'b0;
				mosi = ~mosi;
				half();
				sck = 1'b1;
				half();
				sck = 1'b0;
				mosi = tx[31-i];
				half();
				hold_n = 1'b1;
			end
			half();
			// slave samples here; we take its bit
			sck = 1'b1;
			rx[31-i] = miso;
			half();
			sck = 1'b0;
		end
		half();
		cs_n = 1'b1;
		// released line must not keep its last level
		mosi = ~mosi;
	endtask : frame
endmodule : wpc_host
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the wiper position serial slave
`default_nettype none
`include "wpc_map.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, sys_rst, wp_n, miso_o, miso_oe_n, nv_write_busy, standby;
	logic sck, cs_n, hold_n, mosi, line, last;
	logic [`WPC_TAPS-1:0] tap_on;
	logic [31:0] rx;
	int fail_count, cmp_count;
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	initial last = 1'b0;
	always @(negedge clk_sys) if (miso_oe_n === 1'b0) last <= miso_o;
	// no pull on the data line: released shows inverse
	assign line = (miso_oe_n === 1'b0) ? miso_o : ~last;
	wpc_top #(.NVW_CYCLES(400)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .sck(sck),
		.cs_n(cs_n), .hold_n(hold_n), .wp_n(wp_n), .mosi(mosi), .slave_addr_bit0(1'b0),
		.slave_addr_bit1(1'b1), .miso_o(miso_o), .miso_oe_n(miso_oe_n),
		.nv_write_busy(nv_write_busy), .standby(standby), .tap_on(tap_on));
	wpc_host i_host (.clk_sys(clk_sys), .miso(line), .sck(sck), .cs_n(cs_n),
		.hold_n(hold_n), .mosi(mosi));
	task automatic check(input string nm, input logic [1023:0] seen, input logic [1023:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : check
	function automatic logic [31:0] cmd(logic [3:0] op, logic [1:0] sel, logic [9:0] d,
			logic [3:0] idf = `WPC_ID_TYPE, logic [1:0] adr = 2'b10);
		return {idf, 1'b0, adr, op[0], op[3:1], 1'b0, sel, 2'b00, 6'h00, d};
	endfunction : cmd
	task automatic run(input logic [31:0] w, input int n = 32, input int hp = -1);
		i_host.frame(w, n, hp, rx);
		repeat (8) @(negedge clk_sys);
	endtask : run
	task automatic nvwait();
		int k;
		k = 0;
		while (nv_write_busy !== 1'b0 && k < 600) begin
			@(negedge clk_sys);
			k++;
		end
		check("nv end", k < 600, 1);
	endtask : nvwait
	function automatic logic [1023:0] hot(logic [9:0] p);
		return 1024'(1) << p;
	endfunction : hot
	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (60000) @(negedge clk_sys);
		fail_count++;
		final_report();
	end
	initial begin
		fail_count = 0;
		cmp_count = 0;
		sys_rst = 1'b1;
		wp_n = 1'b1;
		repeat (4) @(negedge clk_sys);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk_sys);
		check("tap rst", tap_on, hot(10'h000));
		check("oe idle", miso_oe_n, 1);
		check("stby", standby, 1);
		$display("test reset done");
		run(cmd(`WPC_OP_WR_WIPER, 2'b00, 10'h2a5), 32, 20);
		check("tap wr", tap_on, hot(10'h2a5));
		run(cmd(`WPC_OP_RD_WIPER, 2'b00, 10'h000));
		check("rd wiper", rx[9:0], 10'h2a5);
		$display("test wiper done");
		for (int k = 0; k < 4; k++) begin
			run(cmd(`WPC_OP_WR_STORED, 2'(k), 10'h0c3 + 10'(k)));
			check("busy", nv_write_busy, 1);
			check("stby busy", standby, 0);
			check("tap keep", tap_on, hot(10'h2a5));
			run(cmd(`WPC_OP_RD_STATUS, 2'b00, 10'h000));
			check("status", rx[8], 1);
			nvwait();
		end
		run(cmd(`WPC_OP_RD_STATUS, 2'b00, 10'h000));
		check("status idle", rx[8], 0);
		for (int k = 0; k < 4; k++) begin
			run(cmd(`WPC_OP_RD_STORED, 2'(k), 10'h000));
			check("rd stored", rx[9:0], 10'h0c3 + 10'(k));
			run(cmd(`WPC_OP_XFR_TO_WIPER, 2'(k), 10'h000), 16);
			check("xfr tap", tap_on, hot(10'h0c3 + 10'(k)));
		end
		run(cmd(`WPC_OP_XFR_TO_STORED, 2'b01, 10'h000), 16);
		nvwait();
		run(cmd(`WPC_OP_RD_STORED, 2'b01, 10'h000));
		check("xfr stored", rx[9:0], 10'h0c6);
		$display("test stored done");
		wp_n = 1'b0;
		run(cmd(`WPC_OP_WR_STORED, 2'b10, 10'h3ff));
		wp_n = 1'b1;
		check("wp busy", nv_write_busy, 0);
		run(cmd(`WPC_OP_RD_STORED, 2'b10, 10'h000));
		check("wp stored", rx[9:0], 10'h0c5);
		run(cmd(`WPC_OP_WR_WIPER, 2'b00, 10'h111, `WPC_ID_TYPE, 2'b01));
		check("adr tap", tap_on, hot(10'h0c6));
		run(cmd(`WPC_OP_WR_WIPER, 2'b00, 10'h111, 4'h6));
		check("id tap", tap_on, hot(10'h0c6));
		run(cmd(`WPC_OP_WR_WIPER, 2'b00, 10'h222), 24);
		check("short tap", tap_on, hot(10'h0c6));
		check("oe after", miso_oe_n, 1);
		$display("test refuse done");
		sys_rst = 1'b1;
		repeat (4) @(negedge clk_sys);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk_sys);
		check("tap rst2", tap_on, hot(10'h000));
		run(cmd(`WPC_OP_WR_WIPER, 2'b00, 10'h3ff));
		check("tap top", tap_on, hot(10'h3ff));
		$display("test reset again done");
		final_report();
	end
endmodule : testbench
`default_nettype wire
